//--- shared/spisd_consts.vh
// constants for the serial status and data path block
`ifndef SPISD_CONSTS_VH
`define SPISD_CONSTS_VH

// register addresses on the plain register port
`define SPISD_ADDR_W         2
`define SPISD_ADDR_CTRL      2'h0
`define SPISD_ADDR_STATUS    2'h1
`define SPISD_ADDR_DATA      2'h2
`define SPISD_ADDR_DDR       2'h3

// control register fields and reset value
`define SPISD_CTRL_IE        7
`define SPISD_CTRL_SPE       6
`define SPISD_CTRL_WOM       5
`define SPISD_CTRL_MASTER_SELECT      4
`define SPISD_CTRL_CPOL      3
`define SPISD_CTRL_CLOCK_PHASE      2
`define SPISD_CTRL_RESET     8'h04

// status register fields
`define SPISD_STAT_TC        7
`define SPISD_STAT_WRITE_COLLISION_FLAG      6
`define SPISD_STAT_MODE_FAULT_FLAG      4

// port d direction bits: width, reset, serial pin positions
`define SPISD_DDR_W          6
`define SPISD_DDR_RESET      6'h00
`define SPISD_DDR_MISO       2
`define SPISD_DDR_MOSI       3
`define SPISD_DDR_SCK        4
`define SPISD_DDR_SS         5
`define SPISD_DDR_SPI_CLR    6'h03

// serial clock half periods in core clocks, minus one, for rate selects 0..3
`define SPISD_HALF_R0        4'h0
`define SPISD_HALF_R1        4'h1
`define SPISD_HALF_R2        4'h7
`define SPISD_HALF_R3        4'hf

// byte transfer length: last half clock period index, and bits per byte
`define SPISD_LAST_HALF      4'hf
`define SPISD_BITS           4'h8

`endif

//--- src/spisd_sync.v
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
module spisd_sync #(
  parameter         W   = 4,
  // reset level per bit, so an idle-high pin shows no false edge
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         core_clk,
  input  wire         sys_rst,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  genvar i;
  // one pair of flops per bit; the first flop feeds only the second
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q <= RST[i];
          sync_q <= RST[i];
        end else begin
          meta_q <= async_i[i];
          sync_q <= meta_q;
        end
      end
      assign sync_o[i] = sync_q;
    end
  endgenerate
endmodule

//--- src/spisd_core.v
// serial peripheral status flags, data path and shift engine
//
// What this block does
// [R01] set transfer complete at end of each byte
// [R02] interrupt when complete flag and enable set
// [R03] clear complete: status read then data access
// [R04] ignore data writes while complete flag unseen
// [R05] data write during transfer sets collision flag
// [R06] phase zero: transfer spans select low period
// [R07] phase one: first edge until complete flag
// [R08] clear collision: status read then data access
// [R09] unused status bits read as zero
// [R10] mode fault only as master, select low
// [R11] mode fault: interrupt, disable, slave, pins input
// [R12] clear mode fault: status read, control write
// [R13] software restores enable, master, direction afterwards
// [R14] only master data writes start a transfer
// [R15] data reads return receive buffer, not shifter
// [R16] byte arriving while flag set is lost
// [R17] data write loads shifter directly, no buffer
// [R18] colliding write leaves active transfer untouched
// [R19] select as output disables mode fault
// [R20] clears affect only flags seen set before
`timescale 1ns/1ps
`include "spisd_consts.vh"
module spisd_core (
  input  wire                      core_clk,
  input  wire                      sys_rst,
  input  wire [`SPISD_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  output wire                      irq,
  input  wire                      sck_i,
  output wire                      sck_o,
  output wire                      sck_oe,
  input  wire                      mosi_i,
  output wire                      mosi_o,
  output wire                      mosi_oe,
  input  wire                      miso_i,
  output wire                      miso_o,
  output wire                      miso_oe,
  input  wire                      ss_n_i,
  output wire                      ss_n_o,
  output wire                      ss_n_oe,
  input  wire                      ss_gpio_level
);

  localparam ST_IDLE = 1'b0;
  localparam ST_MBUSY = 1'b1;

  // register state
  reg  [7:0]              ctrl_q;
  reg  [`SPISD_DDR_W-1:0] ddr_q;
  reg                     tc_q;
  reg                     write_collision_flag_q;
  reg                     mode_fault_flag_q;
  reg                     seen_tc_q;
  reg                     seen_write_collision_flag_q;
  reg                     seen_mode_fault_flag_q;
  reg  [7:0]              rxbuf_q;
  // shift engine state
  reg                     state_q;
  reg  [7:0]              shreg_q;
  reg                     samp_q;
  reg                     out_q;
  reg  [3:0]              half_q;
  reg  [3:0]              div_q;
  reg                     msck_q;
  reg  [3:0]              sbits_q;
  reg                     sact1_q;
  reg                     sck_prev_q;

  wire [3:0] pin_s;
  wire       sck_s  = pin_s[0];
  wire       mosi_s = pin_s[1];
  wire       miso_s = pin_s[2];
  wire       ss_low = ~pin_s[3];

  wire ie   = ctrl_q[`SPISD_CTRL_IE];
  wire serial_system_enable  = ctrl_q[`SPISD_CTRL_SPE];
  wire wom  = ctrl_q[`SPISD_CTRL_WOM];
  wire master_select = ctrl_q[`SPISD_CTRL_MASTER_SELECT];
  wire cpol = ctrl_q[`SPISD_CTRL_CPOL];
  wire clock_phase = ctrl_q[`SPISD_CTRL_CLOCK_PHASE];

  // pins cross from the link side through two flops each
  spisd_sync #(.W(4), .RST(4'h8)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_i  ({ss_n_i, miso_i, mosi_i, sck_i}),
    .sync_o   (pin_s)
  );

  // decoded register accesses
  wire wr_ctrl  = reg_wr && (reg_addr == `SPISD_ADDR_CTRL);
  wire rd_stat  = reg_rd && (reg_addr == `SPISD_ADDR_STATUS);
  wire wr_data  = reg_wr && (reg_addr == `SPISD_ADDR_DATA);
  wire rd_data  = reg_rd && (reg_addr == `SPISD_ADDR_DATA);
  wire wr_ddr   = reg_wr && (reg_addr == `SPISD_ADDR_DDR);
  wire acc_data = wr_data || rd_data;

  // master half period from the rate selects
  reg [3:0] half_lim;
  always @* begin
    case (ctrl_q[1:0])
      2'b00:   half_lim = `SPISD_HALF_R0;
      2'b01:   half_lim = `SPISD_HALF_R1;
      2'b10:   half_lim = `SPISD_HALF_R2;
      default: half_lim = `SPISD_HALF_R3;
    endcase
  end
  wire div_tick = (state_q == ST_MBUSY) && (div_q == half_lim);

  // slave edges seen on the synchronised clock
  wire slave_on  = serial_system_enable && !master_select;
  wire sck_act   = sck_s ^ cpol;
  wire prev_act  = sck_prev_q ^ cpol;
  wire s_lead    = slave_on && ss_low && sck_act && !prev_act;
  wire s_trail   = slave_on && ss_low && !sck_act && prev_act;

  // one leading/trailing edge strobe shared by master and slave
  wire m_lead  = div_tick && !half_q[0];
  wire m_trail = div_tick && half_q[0];
  wire lead    = (state_q == ST_MBUSY) ? m_lead : s_lead;
  wire trail   = (state_q == ST_MBUSY) ? m_trail : s_trail;
  wire rx_bit  = (state_q == ST_MBUSY) ? miso_s : mosi_s;

  // end of byte in either role
  wire m_done = m_trail && (half_q == `SPISD_LAST_HALF);
  wire s_done = s_trail && (sbits_q == `SPISD_BITS - 4'h1);
  wire done   = m_done || s_done; // [R01]

  // mode fault is blocked while select serves as a general output
  wire mode_fault_flag_set = master_select && !ddr_q[`SPISD_DDR_SS] && ss_low; // [R10] [R19]

  // transfer in progress as seen by the collision check
  wire busy = (state_q == ST_MBUSY) ||
              (slave_on && !clock_phase && ss_low) ||    // [R06]
              (slave_on && clock_phase && sact1_q);      // [R07]

  // a data write is refused while the complete flag is unseen
  wire wr_allowed = wr_data && !(tc_q && !seen_tc_q); // [R04]
  wire collide    = wr_allowed && busy;               // [R05]
  wire load_shreg = wr_allowed && !busy;              // [R17] [R18]

  // clears apply only to flags that the last status read saw
  wire clr_tc   = acc_data && seen_tc_q;   // [R03] [R20]
  wire clr_write_collision_flag = acc_data && seen_write_collision_flag_q; // [R08] [R20]
  wire clr_mode_fault_flag = wr_ctrl && seen_mode_fault_flag_q;  // [R12] [R20]

  // shifted byte after the final edge, used for the receive buffer
  wire [7:0] rx_byte = clock_phase ? {shreg_q[6:0], rx_bit}
                            : {shreg_q[6:0], samp_q};

  // control and direction registers, with the forced fault effects
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `SPISD_CTRL_RESET;
      ddr_q  <= `SPISD_DDR_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_ddr) begin
        ddr_q <= reg_wdata[`SPISD_DDR_W-1:0];
      end
      // the fault overrides any write in the same cycle
      if (mode_fault_flag_set) begin
        ctrl_q[`SPISD_CTRL_SPE]  <= 1'b0;             // [R11]
        ctrl_q[`SPISD_CTRL_MASTER_SELECT] <= 1'b0;             // [R11]
        ddr_q <= ddr_q & `SPISD_DDR_SPI_CLR;          // [R11]
      end
    end
  end

  // status flags: a set in the clearing cycle wins
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tc_q        <= 1'b0;
      write_collision_flag_q      <= 1'b0;
      mode_fault_flag_q      <= 1'b0;
      seen_tc_q   <= 1'b0;
      seen_write_collision_flag_q <= 1'b0;
      seen_mode_fault_flag_q <= 1'b0;
    end else begin
      if (done) begin
        tc_q <= 1'b1;                                 // [R01]
      end else if (clr_tc) begin
        tc_q <= 1'b0;                                 // [R03]
      end
      if (collide) begin
        write_collision_flag_q <= 1'b1;                               // [R05]
      end else if (clr_write_collision_flag) begin
        write_collision_flag_q <= 1'b0;                               // [R08]
      end
      if (mode_fault_flag_set) begin
        mode_fault_flag_q <= 1'b1;                               // [R10]
      end else if (clr_mode_fault_flag) begin
        mode_fault_flag_q <= 1'b0;                               // [R12]
      end
      // a status read records which flags it saw set
      if (rd_stat) begin
        seen_tc_q   <= tc_q;
        seen_write_collision_flag_q <= write_collision_flag_q;
        seen_mode_fault_flag_q <= mode_fault_flag_q;
      end else begin
        if (acc_data) begin
          seen_tc_q   <= 1'b0;
          seen_write_collision_flag_q <= 1'b0;
        end
        if (wr_ctrl) begin
          seen_mode_fault_flag_q <= 1'b0;
        end
      end
    end
  end

  // receive buffer; the reader never sees the live shifter
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxbuf_q <= 8'h00;
    end else if (done && !(tc_q && !clr_tc)) begin
      rxbuf_q <= rx_byte;                             // [R15] [R16]
    end
  end

  // master state machine and clock divider
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      div_q   <= 4'h0;
      half_q  <= 4'h0;
      msck_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          div_q  <= 4'h0;
          half_q <= 4'h0;
          msck_q <= 1'b0;
          if (load_shreg && serial_system_enable && master_select && !mode_fault_flag_set) begin
            state_q <= ST_MBUSY;                      // [R14]
          end
        end
        default: begin
          if (mode_fault_flag_set) begin
            state_q <= ST_IDLE;                       // [R11]
          end else if (div_tick) begin
            div_q  <= 4'h0;
            half_q <= half_q + 4'h1;
            msck_q <= ~half_q[0];
            if (m_done) begin
              state_q <= ST_IDLE;
            end
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
      endcase
    end
  end

  // shifter: loaded by a data write, clocked by lead and trail edges
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shreg_q <= 8'h00;
      samp_q  <= 1'b0;
      out_q   <= 1'b0;
    end else if (load_shreg) begin
      shreg_q <= reg_wdata;                           // [R17]
      out_q   <= reg_wdata[7];
    end else begin
      if (lead) begin
        samp_q <= rx_bit;
        out_q  <= shreg_q[7];
      end
      if (trail) begin
        shreg_q <= rx_byte;
      end
    end
  end

  // slave bit count and phase one activity window
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sbits_q    <= 4'h0;
      sact1_q    <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      // in either phase the byte restarts whenever select goes high
      if (!slave_on || !ss_low) begin
        sbits_q <= 4'h0;
      end else if (s_done) begin
        sbits_q <= 4'h0;
      end else if (s_trail) begin
        sbits_q <= sbits_q + 4'h1;
      end
      if (!slave_on || s_done) begin
        sact1_q <= 1'b0;                              // [R07]
      end else if (s_lead && clock_phase) begin
        sact1_q <= 1'b1;                              // [R07]
      end
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `SPISD_ADDR_CTRL) begin
        reg_rdata <= ctrl_q;
      end else if (reg_addr == `SPISD_ADDR_STATUS) begin
        reg_rdata <= {tc_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0}; // [R09]
      end else if (reg_addr == `SPISD_ADDR_DATA) begin
        reg_rdata <= rxbuf_q;                         // [R15]
      end else begin
        reg_rdata <= {2'b00, ddr_q};
      end
    end
  end

  // interrupt request from either flag
  assign irq = ie && (tc_q || mode_fault_flag_q);                // [R02] [R11]

  // pin drive; wired-or mode only ever pulls low
  wire data_out = clock_phase ? out_q : shreg_q[7];
  wire sck_val  = msck_q ^ cpol;
  wire en_sck   = serial_system_enable && master_select && ddr_q[`SPISD_DDR_SCK];
  wire en_mosi  = serial_system_enable && master_select && ddr_q[`SPISD_DDR_MOSI];
  wire en_miso  = slave_on && ss_low && ddr_q[`SPISD_DDR_MISO];
  wire en_ss    = ddr_q[`SPISD_DDR_SS];             // [R19]

  assign sck_o   = wom ? 1'b0 : sck_val;
  assign sck_oe  = en_sck && (!wom || !sck_val);
  assign mosi_o  = wom ? 1'b0 : data_out;
  assign mosi_oe = en_mosi && (!wom || !data_out);
  assign miso_o  = wom ? 1'b0 : data_out;
  assign miso_oe = en_miso && (!wom || !data_out);
  assign ss_n_o  = wom ? 1'b0 : ss_gpio_level;
  assign ss_n_oe = en_ss && (!wom || !ss_gpio_level);

endmodule

//--- test/spisd_core_props.sv
// assertion checker for the serial status and data path
`timescale 1ns/1ps
`include "spisd_consts.vh"
module spisd_props (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       ss_n_o,
  input wire logic       ss_n_oe,
  input wire logic       ss_gpio_level
);
  logic ie_q; // enable as last written
  logic st_q; // status read taken on last edge
  // a mode fault never clears the enable, so the last write holds
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ie_q <= 1'b0;
      st_q <= 1'b0;
    end else begin
      st_q <= reg_rd && reg_addr == `SPISD_ADDR_STATUS;
      if (reg_wr && reg_addr == `SPISD_ADDR_CTRL)
        ie_q <= reg_wdata[`SPISD_CTRL_IE];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
  property p_unused; st_q |-> reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0;
  endproperty
  property p_irq_ie; !ie_q |-> !irq; endproperty
  property p_irq_flag; st_q && reg_rdata[7] && ie_q |-> irq; endproperty
  property p_fault;
    st_q && reg_rdata[4] |-> !mosi_oe && !sck_oe && !miso_oe && irq == ie_q;
  endproperty
  property p_roles; mosi_oe |-> !miso_oe; endproperty
  property p_slv_clk; miso_oe |-> !sck_oe; endproperty
  property p_ss_out;
    ss_n_oe && $past(ss_n_oe) && $stable(ss_gpio_level)
      |-> ss_n_o == ss_gpio_level;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  a_unused: assert property (p_unused)
    else $error("unused status bit set");
  a_irq_ie: assert property (p_irq_ie)
    else $error("irq while disabled");
  a_irq_flag: assert property (p_irq_flag)
    else $error("no irq with complete flag");
  a_fault: assert property (p_fault)
    else $error("fault left pins driven");
  a_roles: assert property (p_roles)
    else $error("master and slave data both driven");
  a_slv_clk: assert property (p_slv_clk)
    else $error("slave drives clock");
  a_ss_out: assert property (p_ss_out)
    else $error("select output level wrong");
  c_done: cover property (st_q && reg_rdata[7]);
  c_coll: cover property (st_q && reg_rdata[6]);
  c_fault: cover property (st_q && reg_rdata[4]);
endmodule
bind spisd_core spisd_props spisd_props_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .ss_gpio_level(ss_gpio_level));

//--- test/spisd_far.sv
// far-side serial device: slave to our master, or master itself
`timescale 1ns/1ps
module spisd_far (
  input  wire logic sck_o,
  input  wire logic sck_oe,
  input  wire logic mosi_o,
  input  wire logic mosi_oe,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  input  wire logic ss_n_o,
  input  wire logic ss_n_oe,
  output wire logic sck_i,
  output wire logic mosi_i,
  output wire logic miso_i,
  output wire logic ss_n_i
);
  logic [7:0] sh_q;   // far shifter, msb out first
  logic       in_b;   // bit caught on leading edge
  logic       m_sck;  // own clock, rests low
  logic       m_mosi; // own data when master
  logic       m_ss_n; // select, pulled low to force a fault
  // each wire carries whichever party drives it
  assign sck_i  = sck_oe ? sck_o : m_sck;
  assign mosi_i = mosi_oe ? mosi_o : m_mosi;
  assign miso_i = miso_oe ? miso_o : sh_q[7];
  assign ss_n_i = ss_n_oe ? ss_n_o : m_ss_n;
  initial begin
    sh_q = 8'h00;
    in_b = 1'b0;
    m_sck = 1'b0;
    m_mosi = 1'b0;
    m_ss_n = 1'b1;
  end
  // phase zero: sample on leading edge, shift on trailing one
  always @(posedge sck_i) in_b <= m_ss_n ? mosi_i : miso_i;
  always @(negedge sck_i) sh_q <= {sh_q[6:0], in_b};
  // one byte at a 64 ns period, clock still outside the frame
  task send(input [7:0] b);
    integer i;
    m_ss_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      m_mosi = b[i];
      #32 m_sck = 1'b1;
      #32 m_sck = 1'b0;
    end
    #32 m_ss_n = 1'b1; // select rises between bytes
    m_mosi = ~m_mosi;  // released line must not keep last bit
    #96;               // room for the byte to reach the buffer
  endtask
endmodule

//--- test/tb.sv
// self-checking bench for the serial status and data path
`timescale 1ns/1ps
`include "spisd_consts.vh"
module tb;
  logic       core_clk;
  logic       sys_rst;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       gpio_lvl;
  wire  [7:0] reg_rdata;
  wire        irq, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
  wire        miso_i, miso_o, miso_oe, ss_n_i, ss_n_o, ss_n_oe;
  integer     errors;
  integer     checks;
  spisd_core spisd_core_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o),
    .ss_n_oe(ss_n_oe), .ss_gpio_level(gpio_lvl));
  spisd_far spisd_far_i (.sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .sck_i(sck_i), .mosi_i(mosi_i),
    .miso_i(miso_i), .ss_n_i(ss_n_i));
  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // register port: one-cycle strobes launched right after an edge
  task wr(input [1:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [1:0] a, input [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // bounded wait; running out ends the run as a failure
  task wait_irq;
    integer n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 2000) begin
      errors++;
      give_verdict;
    end
  endtask
  task t_reset;
    rd(`SPISD_ADDR_STATUS, 8'h00);
    rd(`SPISD_ADDR_CTRL, `SPISD_CTRL_RESET);
    rd(`SPISD_ADDR_DDR, 8'h00);
    $display("reset test done");
  endtask
  task t_master;
    spisd_far_i.sh_q = 8'ha5;
    wr(`SPISD_ADDR_DDR, 8'h18);
    wr(`SPISD_ADDR_CTRL, 8'hd3);
    wr(`SPISD_ADDR_DATA, 8'h3c);
    wr(`SPISD_ADDR_DATA, 8'h55);
    wait_irq;
    chk(spisd_far_i.sh_q, 8'h3c);
    rd(`SPISD_ADDR_STATUS, 8'hc0);
    rd(`SPISD_ADDR_DATA, 8'ha5);
    chk({7'h00, irq}, 8'h00);
    rd(`SPISD_ADDR_STATUS, 8'h00);
    wr(`SPISD_ADDR_DATA, 8'h81);
    wait_irq;
    wr(`SPISD_ADDR_DATA, 8'h7e);
    rd(`SPISD_ADDR_STATUS, 8'h80);
    rd(`SPISD_ADDR_DATA, 8'h3c);
    wr(`SPISD_ADDR_DATA, 8'h42);
    wait_irq;
    chk(spisd_far_i.sh_q, 8'h42);
    rd(`SPISD_ADDR_STATUS, 8'h80);
    rd(`SPISD_ADDR_DATA, 8'h81);
    $display("master test done");
  endtask
  task t_slave;
    wr(`SPISD_ADDR_DDR, 8'h04);
    wr(`SPISD_ADDR_CTRL, 8'hc0);
    wr(`SPISD_ADDR_DATA, 8'h5a);
    spisd_far_i.send(8'h96);
    chk(spisd_far_i.sh_q, 8'h5a);
    wait_irq;
    spisd_far_i.send(8'h69);
    rd(`SPISD_ADDR_STATUS, 8'h80);
    rd(`SPISD_ADDR_DATA, 8'h96);
    $display("slave test done");
  endtask
  task t_fault;
    wr(`SPISD_ADDR_DDR, 8'h18);
    wr(`SPISD_ADDR_CTRL, 8'hd0);
    spisd_far_i.m_ss_n = 1'b0;
    wait_irq;
    chk({7'h00, mosi_oe}, 8'h00);
    rd(`SPISD_ADDR_STATUS, 8'h10);
    rd(`SPISD_ADDR_CTRL, 8'h80);
    rd(`SPISD_ADDR_DDR, 8'h00);
    wr(`SPISD_ADDR_CTRL, 8'h80);
    rd(`SPISD_ADDR_STATUS, 8'h00);
    gpio_lvl <= 1'b0;
    wr(`SPISD_ADDR_DDR, 8'h38);
    wr(`SPISD_ADDR_CTRL, 8'hd0);
    rd(`SPISD_ADDR_CTRL, 8'hd0);
    rd(`SPISD_ADDR_STATUS, 8'h00);
    $display("fault test done");
  endtask
  // slave collision window in each clock phase, select held low
  task t_window;
    wr(`SPISD_ADDR_CTRL, 8'hc4);
    wr(`SPISD_ADDR_DDR, 8'h04);
    wr(`SPISD_ADDR_DATA, 8'h11);
    rd(`SPISD_ADDR_STATUS, 8'h00);
    wr(`SPISD_ADDR_CTRL, 8'hc0);
    wr(`SPISD_ADDR_DATA, 8'h22);
    rd(`SPISD_ADDR_STATUS, 8'h40);
    rd(`SPISD_ADDR_DATA, 8'h96);
    rd(`SPISD_ADDR_STATUS, 8'h00);
    wr(`SPISD_ADDR_CTRL, 8'hc4);
    spisd_far_i.m_sck = 1'b1;
    repeat (4) @(posedge core_clk);
    wr(`SPISD_ADDR_DATA, 8'h33);
    rd(`SPISD_ADDR_STATUS, 8'h40);
    spisd_far_i.m_sck = 1'b0;
    spisd_far_i.m_ss_n = 1'b1;
    $display("window test done");
  endtask
  initial begin
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gpio_lvl = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_master;
    t_slave;
    t_fault;
    t_window;
    give_verdict;
  end
endmodule
